// file: dv/ccrlm_host.sv
`timescale 1ns/1ps
module ccrlm_host
  import ccrlm_pkg::*;
(
  // clock
  input  logic clk_sys,
  // serial bus, open drain with pull-up
  input  logic sda,
  output logic scl,
  output logic sda_low
);
  // ------------------------------------------------------------------
  // serial host; half bit of 6 clocks keeps above the 4-clock minimum
  // ------------------------------------------------------------------
  localparam int HALF = 6;
  int nak_cnt = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic b, output logic r);
    hold(1);
    sda_low <= !b;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    r = sda;
    scl <= 1'b0;
  endtask
  // also a repeated start when entered with scl low
  task automatic start();
    hold(1);
    sda_low <= 1'b0;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold(1);
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) pulse(d[i], r[i]);
  endtask
  task automatic send(input logic [7:0] b);
    logic [8:0] r;
    xfer({b, 1'b1}, r);
    if (r[0] !== 1'b0) nak_cnt++;
  endtask
  task automatic write_reg(input logic [7:0] adr, input logic [7:0] dat);
    start();
    send({DEV_ADDR, 1'b0});
    send(adr);
    send(dat);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] adr, output logic [7:0] dat);
    logic [8:0] r;
    start();
    send({DEV_ADDR, 1'b0});
    send(adr);
    start();
    send({DEV_ADDR, 1'b1});
    xfer(9'h1ff, r);
    dat = r[8:1];
    stop();
  endtask
  task automatic power_up_wait();
    hold(20000);
  endtask
endmodule

// file: dv/ccrlm_properties.sv
`timescale 1ns/1ps
module ccrlm_properties
  import ccrlm_pkg::*;
(
  // clock and reset
  input logic                        clk_sys,
  input logic                        rst_b,
  // watched pins
  input logic                        sleep_request_n,
  input logic                        hw_reset_n,
  input logic                        ovp_det,
  input logic [ccrlm_pkg::CUR_W-1:0] sense_ma,
  input logic                        int_n,
  input logic                        conv_enable,
  input logic                        fast_pd,
  input ccrlm_pkg::ccrlm_mode_e      mode,
  input logic [3:0]                  freq_trim
);
  // ------------------------------------------------------------------
  // properties; pin inputs pass a 2-flop synchroniser, hence the slack
  // ------------------------------------------------------------------
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_FPD_ON: assert property (
    conv_enable ##1 (ovp_det && hw_reset_n) [*4] |-> ##[0:3] fast_pd)
    else $error("overvoltage gave no fast power-down");
  AST_FPD_OFF: assert property (
    fast_pd |=> !conv_enable)
    else $error("converter on during fast power-down");
  AST_PIN_OFF: assert property (
    !hw_reset_n [*5] |-> !conv_enable)
    else $error("converter on while reset pin low");
  AST_PWM_HIGH: assert property (
    (sense_ma >= 15'h177) [*2] |-> mode == MODE_PWM)
    else $error("no pwm above highest trip point");
  AST_SLEEP_LP: assert property (
    (!sleep_request_n && sense_ma < 15'h064) [*5] |-> mode != MODE_PFM)
    else $error("sleep request ignored");
  AST_TRIM_OFF: assert property (
    !conv_enable [*2] |-> freq_trim == 4'h0)
    else $error("frequency offset while converter off");
  AST_INT_HOLD: assert property (
    $fell(int_n) |=> !int_n [*8])
    else $error("interrupt released without clear");
  AST_INT_FAULT: assert property (
    ovp_det [*4] |-> ##[0:3] !int_n)
    else $error("overvoltage raised no interrupt");
endmodule

bind ccrlm_top ccrlm_properties u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .sleep_request_n(sleep_request_n),
  .hw_reset_n(hw_reset_n), .ovp_det(ovp_det), .sense_ma(sense_ma),
  .int_n(int_n), .conv_enable(conv_enable), .fast_pd(fast_pd),
  .mode(mode), .freq_trim(freq_trim)
);

// file: dv/ccrlm_tb_top.sv
`timescale 1ns/1ps
module ccrlm_tb_top;
  import ccrlm_pkg::*;
  // ------------------------------------------------------------------
  // bench
  // ------------------------------------------------------------------
  logic                  clk_sys = 1'b0, rst_b = 1'b0;
  logic                  sleep_request_n = 1'b1, hw_reset_n = 1'b0;
  logic                  io_supply_line = 1'b1;
  logic [2:0]            flt = 3'h0;
  logic [CUR_W-1:0]      sense_ma = '0;
  logic                  scl, sda_low, sda_out, sda_oe, int_n;
  logic                  conv_enable, fast_pd;
  ccrlm_mode_e           mode;
  logic [3:0]            freq_trim, last;
  logic [SEL_CORE_W-1:0] core_sel, c;
  logic [6:0]            vout_code, v;
  logic [7:0]            rd, codes [4];
  logic [10:0]           r;
  int                    failures = 0, n_tests = 0, s, n;
  wire                   sda = !(sda_low | (sda_oe & !sda_out));

  always #12.5 clk_sys = !clk_sys;

  ccrlm_top dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .sleep_request_n(sleep_request_n),
    .hw_reset_n(hw_reset_n), .io_supply_line(io_supply_line),
    .int_n(int_n), .ovp_det(flt[0]), .uvlo_det(flt[1]), .thsd_det(flt[2]),
    .sense_ma(sense_ma), .conv_enable(conv_enable), .fast_pd(fast_pd),
    .mode(mode), .freq_trim(freq_trim), .meas_core_sel(core_sel),
    .vout_code(vout_code)
  );
  ccrlm_host host (.clk_sys(clk_sys), .sda(sda), .scl(scl),
                   .sda_low(sda_low));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
    host.read_reg(adr, rd);
    check(rd, exp);
  endtask
  function automatic int trip_exp(input int code);
    return TRIP_BASE_MA + TRIP_STEP_MA *
           (code > TRIP_MAX_CODE ? TRIP_MAX_CODE : code);
  endfunction
  function automatic logic [10:0] res_exp(input int ma);
    return (ma / RES_LSB_MA > RES_MAX_CODE) ? 11'(RES_MAX_CODE)
                                            : 11'(ma / RES_LSB_MA);
  endfunction

  // a hang ends the run through the same verdict
  initial begin
    wt(95000);
    failures++;
    give_verdict();
  end

  initial begin
    void'($urandom(3918));
    codes = '{8'h00, 8'($urandom_range(10, 1)), 8'h0b, 8'h0f};
    wt(6);
    rst_b <= 1'b1;
    hw_reset_n <= 1'b1;
    host.power_up_wait();
    rchk(ADR_FLAGS, 8'h00);
    rchk(ADR_SEL, 8'h00);
    rchk(ADR_RESET, 8'h00);
    rchk(8'h30, 8'h00);
    $display("test reset done");
    foreach (codes[i]) begin
      host.write_reg(ADR_TRIP, codes[i]);
      sense_ma <= CUR_W'(trip_exp(codes[i]));
      wt(4);
      check(mode, MODE_PWM);
      sense_ma <= CUR_W'(trip_exp(codes[i]) - 1);
      wt(4);
      check(mode, MODE_PFM);
    end
    sense_ma <= CUR_W'(20);
    wt(2);
    sleep_request_n <= 1'b0;
    wt(6);
    check(mode, MODE_LPPFM);
    sleep_request_n <= 1'b1;
    wt(4000);
    check(mode, MODE_PFM);
    host.write_reg(ADR_CTRL, 8'h01);
    wt(4);
    check(mode, MODE_LPPFM);
    host.write_reg(ADR_FPWM, 8'h01);
    wt(4);
    check(mode, MODE_PWM);
    $display("test modes done");
    v = 7'($urandom);
    host.write_reg(ADR_VSET, {1'b1, v});
    wt(4);
    check(conv_enable, 1'b1);
    check(vout_code, v);
    check(freq_trim, 4'h0);
    host.write_reg(ADR_CTRL, 8'h02);
    n = 0;
    last = freq_trim;
    for (int i = 0; i < 2000; i++) begin
      wt(1);
      if (freq_trim !== last) n++;
      last = freq_trim;
    end
    check(n > 1, 1'b1);
    hw_reset_n <= 1'b0;
    wt(60);
    check(conv_enable, 1'b0);
    hw_reset_n <= 1'b1;
    wt(1002);
    check(conv_enable, 1'b1);
    rchk(ADR_FPWM, 8'h00);
    rchk(ADR_CTRL, 8'h00);
    rchk(ADR_VSET, {1'b1, v});
    $display("test enable done");
    for (int i = 0; i < 4; i++) begin
      c = SEL_CORE_W'($urandom);
      s = (i == 0) ? 25000 : (i == 1) ? 0 : $urandom_range(19999, 1);
      sense_ma <= CUR_W'(s);
      host.write_reg(ADR_MASK3, {7'h0, i == 3});
      host.write_reg(ADR_SEL, {5'h0, c});
      rchk(ADR_FLAGS, 8'h00);
      wt(2000);
      check(int_n, i == 3);
      check(core_sel, c);
      rchk(ADR_FLAGS, 8'h08);
      r = res_exp(s);
      rchk(ADR_RESULT, r[7:0]);
      rchk(ADR_SEL, {r[10:8], 2'b00, c});
      host.write_reg(ADR_FLAGS, 8'h08);
      check(int_n, 1'b1);
    end
    host.write_reg(ADR_SEL, 8'h01);
    wt(1400);
    host.write_reg(ADR_SEL, 8'h02);
    rchk(ADR_FLAGS, 8'h00);
    wt(2000);
    rchk(ADR_FLAGS, 8'h08);
    host.write_reg(ADR_FLAGS, 8'h08);
    $display("test measure done");
    for (int k = 0; k < 3; k++) begin
      flt <= 3'(1 << k);
      wt(8);
      check(fast_pd, 1'b1);
      check(int_n, 1'b0);
      flt <= 3'h0;
      wt(8);
      rchk(ADR_FLAGS, 8'(1 << k));
      host.write_reg(ADR_FLAGS, 8'(1 << k));
      check(int_n, 1'b1);
    end
    host.write_reg(ADR_CTRL, 8'h03);
    flt <= 3'h1;
    wt(8);
    flt <= 3'h0;
    host.write_reg(ADR_RESET, 8'h01);
    host.write_reg(ADR_RESET, 8'h00);
    wt(1010);
    rchk(ADR_CTRL, 8'h00);
    rchk(ADR_FLAGS, 8'h01);
    check(conv_enable, 1'b1);
    $display("test faults done");
    io_supply_line <= 1'b0;
    wt(8);
    check(fast_pd, 1'b1);
    io_supply_line <= 1'b1;
    host.power_up_wait();
    rchk(ADR_VSET, 8'h00);
    rchk(ADR_FLAGS, 8'h00);
    check(conv_enable, 1'b0);
    check(16'(host.nak_cnt), 16'h0000);
    $display("test power-on done");
    give_verdict();
  end
endmodule

// file: src/ccrlm_meas.sv
`timescale 1ns/1ps
module ccrlm_meas
  import ccrlm_pkg::*;
(
  // clock and reset
  input  logic                         clk_sys,
  input  logic                         rst_b,
  // control
  input  logic                         start,
  input  logic [ccrlm_pkg::CUR_W-1:0]  sense_ma,
  // result
  output logic                         busy,
  output logic                         done,
  output logic [ccrlm_pkg::RES_W-1:0]  result
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [11:0]      cnt;
    logic [RES_W-1:0] res;
  } ccrlm_meas_s;

  ccrlm_meas_s q, d;
  logic [CUR_W-1:0] code;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    code   = sense_ma / CUR_W'(RES_LSB_MA);
    if (start) begin
      // a new start restarts the window and suppresses a pending finish
      d.busy = 1'b1;
      d.cnt  = 12'(MEAS_CYC);
    end else if (q.busy) begin
      d.cnt = q.cnt - 12'h001;
      if (q.cnt == 12'h001) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.res  = (code > CUR_W'(RES_MAX_CODE)) ? RES_W'(RES_MAX_CODE)
                                                : code[RES_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy   = q.busy;
  assign done   = q.done;
  assign result = q.res;

endmodule

// file: src/ccrlm_pkg.sv
package ccrlm_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADR_VSET   = 8'h00;
  localparam logic [7:0] ADR_FPWM   = 8'h06;
  localparam logic [7:0] ADR_CTRL   = 8'h07;
  localparam logic [7:0] ADR_FLAGS  = 8'h0e;
  localparam logic [7:0] ADR_RESET  = 8'h11;
  localparam logic [7:0] ADR_DELAY  = 8'h12;
  localparam logic [7:0] ADR_TRIP   = 8'h19;
  localparam logic [7:0] ADR_SEL    = 8'h21;
  localparam logic [7:0] ADR_RESULT = 8'h22;
  localparam logic [7:0] ADR_MASK3  = 8'h2e;

  // field positions
  localparam int VSET_EN_BIT    = 7;
  localparam int FPWM_BIT       = 0;
  localparam int CTRL_LP_BIT    = 0;
  localparam int CTRL_SS_BIT    = 1;
  localparam int FLG_OVP_BIT    = 0;
  localparam int FLG_UVLO_BIT   = 1;
  localparam int FLG_THSD_BIT   = 2;
  localparam int FLG_READY_BIT  = 3;
  localparam int RST_SW_BIT     = 0;
  localparam int MASK3_RDY_BIT  = 0;
  localparam int SEL_CORE_W     = 3;
  localparam int SEL_RES_LSB    = 5;
  localparam int RES_W          = 11;
  localparam int CUR_W          = 15;

  // factory (one-time-programmed) and reset values
  localparam logic [7:0] VSET_OTP  = 8'h00;
  localparam logic [7:0] TRIP_OTP  = 8'h06;
  localparam logic [7:0] CLEAR_RST = 8'h00;
  localparam logic [6:0] DEV_ADDR  = 7'h2c;  // arbitrary bus address

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MEAS_MIN_US   = 50;
  localparam int MEAS_CYC      = (MEAS_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RELOAD_MAX_US = 25;
  localparam int RELOAD_CYC    = (RELOAD_MAX_US * 1000) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // current scaling
  // ------------------------------------------------------------------
  localparam int TRIP_BASE_MA  = 100;
  localparam int TRIP_STEP_MA  = 25;
  localparam int TRIP_MAX_CODE = 11;
  localparam int RES_LSB_MA    = 10;
  localparam int RES_FULL_MA   = 20000;
  localparam int RES_MAX_CODE  = RES_FULL_MA / RES_LSB_MA;

  typedef enum logic [1:0] {
    MODE_PFM   = 2'b00,
    MODE_LPPFM = 2'b01,
    MODE_PWM   = 2'b10
  } ccrlm_mode_e;

  typedef enum logic [1:0] {
    SEQ_LOAD = 2'b00,
    SEQ_STBY = 2'b01,
    SEQ_ACT  = 2'b10,
    SEQ_FPD  = 2'b11
  } ccrlm_seq_e;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_DEV  = 3'b001,
    I2C_REG  = 3'b010,
    I2C_WR   = 3'b011,
    I2C_ACK  = 3'b100,
    I2C_RD   = 3'b101,
    I2C_RACK = 3'b110
  } ccrlm_i2c_e;

  // pwm trip point in mA; codes above the top step clamp to it
  function automatic logic [CUR_W-1:0] trip_ma(input logic [7:0] code);
    int c;
    c = (int'(code) > TRIP_MAX_CODE) ? TRIP_MAX_CODE : int'(code);
    return CUR_W'(TRIP_BASE_MA + c * TRIP_STEP_MA);
  endfunction

endpackage

// file: src/ccrlm_spread.sv
`timescale 1ns/1ps
module ccrlm_spread (
  // clock and reset
  input  logic       clk_sys,
  input  logic       rst_b,
  // control
  input  logic       enable,
  // frequency offset around centre, zero when off
  output logic [3:0] freq_trim
);

  typedef struct packed {
    logic [7:0] lfsr;
    logic [3:0] trim;
  } ccrlm_ss_s;

  ccrlm_ss_s q, d;

  always_comb begin
    d      = q;
    d.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
    d.trim = enable ? q.lfsr[3:0] : 4'h0;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q      <= '0;
      q.lfsr <= 8'h01;
    end else begin
      q <= d;
    end
  end

  assign freq_trim = q.trim;

endmodule

// file: src/ccrlm_top.sv
// Behaviour
// - pwm at or above programmed trip, else pfm
// - control bit enables low-power pfm
// - sleep request low forces low-power pfm
// - select register chooses core or total current
// - select write starts 50 us measurement
// - ready flag cleared at start, set at end
// - result bits split over two registers
// - result 10 mA per lsb, saturates 20 A
// - measurement end interrupts unless masked
// - spread spectrum randomises switching frequency
// - after power-on, load factory values, standby
// - converter enabled by bit while reset pin high
// - reset bit 1 then 0 resets controls
// - fault flags survive software reset
// - power-on reset loads factory values everywhere but the measurement result
// - reset pin low resets control registers
// - faults or supply low cause fast power-down, except during reload
// - reload finishes within 25 us
// - interrupt low while unmasked flag set
`timescale 1ns/1ps
module ccrlm_top
  import ccrlm_pkg::*;
(
  // clock and reset
  input  logic                           clk_sys,
  input  logic                           rst_b,
  // serial register interface
  input  logic                           scl,
  input  logic                           sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // system pins
  input  logic                           sleep_request_n,
  input  logic                           hw_reset_n,
  input  logic                           io_supply_line,
  output logic                           int_n,
  // analog monitors
  input  logic                           ovp_det,
  input  logic                           uvlo_det,
  input  logic                           thsd_det,
  input  logic [ccrlm_pkg::CUR_W-1:0]    sense_ma,
  // converter control
  output logic                           conv_enable,
  output logic                           fast_pd,
  output ccrlm_pkg::ccrlm_mode_e         mode,
  output logic [3:0]                     freq_trim,
  output logic [ccrlm_pkg::SEL_CORE_W-1:0] meas_core_sel,
  output logic [6:0]                     vout_code
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_SLP = 2;
  localparam int SY_RST = 3;
  localparam int SY_IO  = 4;
  localparam int SY_OVP = 5;
  localparam int SY_UV  = 6;
  localparam int SY_TH  = 7;

  typedef struct packed {
    logic [7:0]            s1;
    logic [7:0]            s2;
    logic                  scl3;
    logic                  sda3;
    logic                  io3;
    ccrlm_i2c_e            ist;
    ccrlm_i2c_e            nxt;
    logic [3:0]            bitc;
    logic [7:0]            shf;
    logic [7:0]            ptr;
    logic                  oe;
    logic [7:0]            vset;
    logic [7:0]            fpwm;
    logic [7:0]            ctrl;
    logic [7:0]            flags;
    logic [7:0]            delay;
    logic [7:0]            trip;
    logic [SEL_CORE_W-1:0] sel;
    logic [7:0]            mask3;
    logic                  sw_arm;
    logic                  mstart;
    ccrlm_seq_e            sst;
    logic [9:0]            cnt;
    logic                  en;
    logic                  fpd;
    ccrlm_mode_e           mode;
    logic                  int_n;
  } ccrlm_top_s;

  ccrlm_top_s q, d;

  logic             m_done;
  logic [RES_W-1:0] m_res;

  // scratch of the combinational process
  logic       scl_s, sda_s, slp_n, hw_reset_n_s, io_s;
  logic       rise, fall, start_c, stop_c, ld;
  logic       wr, swrst, por_evt, fault;
  logic [7:0] rbyte, irq_en;

  // ------------------------------------------------------------------
  // register read view
  // ------------------------------------------------------------------
  function automatic logic [7:0] rd_reg(input ccrlm_top_s s,
                                        input logic [7:0] adr,
                                        input logic [RES_W-1:0] res);
    case (adr)
      ADR_VSET:   rd_reg = s.vset;
      ADR_FPWM:   rd_reg = s.fpwm;
      ADR_CTRL:   rd_reg = s.ctrl;
      ADR_FLAGS:  rd_reg = s.flags;
      ADR_DELAY:  rd_reg = s.delay;
      ADR_TRIP:   rd_reg = s.trip;
      ADR_SEL:    rd_reg = {res[RES_W-1:8], 2'b00, s.sel};
      ADR_RESULT: rd_reg = res[7:0];
      ADR_MASK3:  rd_reg = s.mask3;
      default:    rd_reg = 8'h00;
    endcase
  endfunction

  always_comb begin
    d       = q;
    d.s1    = {thsd_det, uvlo_det, ovp_det, io_supply_line, hw_reset_n,
               sleep_request_n, sda_in, scl};
    d.s2    = q.s1;
    scl_s   = q.s2[SY_SCL];
    sda_s   = q.s2[SY_SDA];
    slp_n   = q.s2[SY_SLP];
    hw_reset_n_s  = q.s2[SY_RST];
    io_s    = q.s2[SY_IO];
    d.scl3  = scl_s;
    d.sda3  = sda_s;
    d.io3   = io_s;
    d.mstart = 1'b0;
    rise    = scl_s & ~q.scl3;
    fall    = ~scl_s & q.scl3;
    start_c = scl_s & q.sda3 & ~sda_s;
    stop_c  = scl_s & ~q.sda3 & sda_s;
    ld      = 1'b0;
    wr      = 1'b0;
    rbyte   = rd_reg(q, q.ptr, m_res);

    // ----------------------------------------------------------------
    // serial slave: device byte, register pointer, data bytes
    // ----------------------------------------------------------------
    if (start_c) begin
      d.ist  = I2C_DEV;
      d.bitc = 4'h0;
      d.oe   = 1'b0;
    end else if (stop_c) begin
      d.ist = I2C_IDLE;
      d.oe  = 1'b0;
    end else begin
      case (q.ist)
        I2C_DEV, I2C_REG, I2C_WR: begin
          if (rise) begin
            d.shf  = {q.shf[6:0], sda_s};
            d.bitc = q.bitc + 4'h1;
          end else if (fall && q.bitc == 4'h8) begin
            d.bitc = 4'h0;
            d.oe   = 1'b1;
            d.ist  = I2C_ACK;
            case (q.ist)
              I2C_DEV: begin
                if (q.shf[7:1] == DEV_ADDR) begin
                  d.nxt = q.shf[0] ? I2C_RD : I2C_REG;
                end else begin
                  d.oe  = 1'b0;
                  d.ist = I2C_IDLE;
                end
              end
              I2C_REG: begin
                d.ptr = q.shf;
                d.nxt = I2C_WR;
              end
              default: begin
                wr    = 1'b1;
                d.ptr = q.ptr + 8'h01;
                d.nxt = I2C_WR;
              end
            endcase
          end
        end
        I2C_ACK: begin
          if (fall) begin
            d.oe  = 1'b0;
            d.ist = q.nxt;
            ld    = (q.nxt == I2C_RD);
          end
        end
        I2C_RD: begin
          if (rise) begin
            d.bitc = q.bitc + 4'h1;
          end else if (fall) begin
            if (q.bitc == 4'h8) begin
              d.ist  = I2C_RACK;
              d.oe   = 1'b0;
              d.bitc = 4'h0;
            end else begin
              d.shf = {q.shf[6:0], 1'b0};
              d.oe  = ~q.shf[6];
            end
          end
        end
        I2C_RACK: begin
          if (rise && sda_s) begin
            d.ist = I2C_IDLE;
          end else if (fall) begin
            d.ist = I2C_RD;
            ld    = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (ld) begin
      // open drain: a zero bit is driven low, a one is released
      d.shf = rbyte;
      d.oe  = ~rbyte[7];
      d.ptr = q.ptr + 8'h01;
    end

    // ----------------------------------------------------------------
    // register writes and reset classes
    // ----------------------------------------------------------------
    swrst = wr && q.ptr == ADR_RESET && q.sw_arm
            && !q.shf[RST_SW_BIT];
    if (wr) begin
      // any other write between the 1 and the 0 breaks the sequence
      d.sw_arm = (q.ptr == ADR_RESET) && q.shf[RST_SW_BIT];
      case (q.ptr)
        ADR_VSET:  d.vset  = q.shf;
        ADR_FPWM:  d.fpwm  = q.shf;
        ADR_CTRL:  d.ctrl  = q.shf;
        ADR_FLAGS: d.flags = q.flags & ~q.shf;
        ADR_DELAY: d.delay = q.shf;
        ADR_TRIP:  d.trip  = q.shf;
        ADR_SEL: begin
          d.sel    = q.shf[SEL_CORE_W-1:0];
          d.mstart = 1'b1;
        end
        ADR_MASK3: d.mask3 = q.shf;
        default: ;
      endcase
    end

    // hardware sets win over a host clear in the same cycle
    if (q.s2[SY_OVP]) d.flags[FLG_OVP_BIT] = 1'b1;
    if (q.s2[SY_UV])  d.flags[FLG_UVLO_BIT] = 1'b1;
    if (q.s2[SY_TH])  d.flags[FLG_THSD_BIT] = 1'b1;
    if (m_done)       d.flags[FLG_READY_BIT] = 1'b1;
    // a restart beats a finish that lands in the same cycle
    if (d.mstart)     d.flags[FLG_READY_BIT] = 1'b0;

    // flags, vset and select survive both of these
    if (!hw_reset_n_s || swrst) begin
      d.fpwm   = CLEAR_RST;
      d.ctrl   = CLEAR_RST;
      d.delay  = CLEAR_RST;
      d.trip   = CLEAR_RST;
      d.mask3  = CLEAR_RST;
      d.sw_arm = 1'b0;
    end

    // ----------------------------------------------------------------
    // power sequencer
    // ----------------------------------------------------------------
    fault = q.s2[SY_OVP] | q.s2[SY_UV] | q.s2[SY_TH]
            | (~io_s & hw_reset_n_s);
    case (q.sst)
      SEQ_LOAD: begin
        d.cnt = q.cnt + 10'h001;
        // the pin synchroniser spends two cycles of the reload budget
        if (q.cnt == 10'(RELOAD_CYC - 3)) begin
          d.sst = SEQ_STBY;
          d.cnt = 10'h000;
        end
      end
      SEQ_STBY: if (d.vset[VSET_EN_BIT] && hw_reset_n_s) d.sst = SEQ_ACT;
      SEQ_ACT:  if (!d.vset[VSET_EN_BIT] || !hw_reset_n_s) d.sst = SEQ_STBY;
      SEQ_FPD:  if (!fault) d.sst = SEQ_STBY;
      default:  d.sst = SEQ_LOAD;
    endcase
    if (fault && q.sst != SEQ_LOAD) begin
      d.sst = SEQ_FPD;
    end
    // reload restarts when the pin releases or after a software reset
    if (!hw_reset_n_s || swrst) begin
      d.sst = SEQ_LOAD;
      d.cnt = 10'h000;
    end

    // supply toggled low then high: full factory reload
    por_evt = io_s & ~q.io3;
    if (por_evt) begin
      d.vset   = VSET_OTP;
      d.trip   = TRIP_OTP;
      d.fpwm   = CLEAR_RST;
      d.ctrl   = CLEAR_RST;
      d.flags  = CLEAR_RST;
      d.delay  = CLEAR_RST;
      d.mask3  = CLEAR_RST;
      d.sel    = '0;
      d.sw_arm = 1'b0;
      d.sst    = SEQ_LOAD;
      d.cnt    = 10'h000;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    d.en  = (d.sst == SEQ_ACT);
    d.fpd = (d.sst == SEQ_FPD);
    // low-power pfm relies on the host sleeping only at light load
    if (d.fpwm[FPWM_BIT] || sense_ma >= trip_ma(d.trip)) begin
      d.mode = MODE_PWM;
    end else if (d.ctrl[CTRL_LP_BIT] || !slp_n) begin
      d.mode = MODE_LPPFM;
    end else begin
      d.mode = MODE_PFM;
    end
    irq_en = 8'h00;
    irq_en[FLG_OVP_BIT]   = 1'b1;
    irq_en[FLG_UVLO_BIT]  = 1'b1;
    irq_en[FLG_THSD_BIT]  = 1'b1;
    irq_en[FLG_READY_BIT] = ~d.mask3[MASK3_RDY_BIT];
    d.int_n = ~|(d.flags & irq_en);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q       <= '0;
      q.vset  <= VSET_OTP;
      q.trip  <= TRIP_OTP;
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // measurement timer and spread-spectrum source
  // ------------------------------------------------------------------
  ccrlm_meas u_meas (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .start    (q.mstart),
    .sense_ma (sense_ma),
    .busy     (),
    .done     (m_done),
    .result   (m_res)
  );

  ccrlm_spread u_spread (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .enable    (q.ctrl[CTRL_SS_BIT] & q.en),
    .freq_trim (freq_trim)
  );

  assign sda_out       = 1'b0;
  assign sda_oe        = q.oe;
  assign int_n         = q.int_n;
  assign conv_enable   = q.en;
  assign fast_pd       = q.fpd;
  assign mode          = q.mode;
  assign meas_core_sel = q.sel;
  assign vout_code     = q.vset[6:0];

endmodule
